// ==== src/byte_ram.sv ====
/*
  Single-port byte memory with registered read data.
  Assumes one address per cycle; a read returns the old value when the
  same address is written in that cycle.
*/
`timescale 1ns/10ps
module byte_ram #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : byte_ram

// ==== src/flash_core_pkg.sv ====
/*
  Shared constants and types for the serial paged flash write core:
  command codes, array geometry, frame and engine states, job carrier.
  Assumes a byte-wide array of 1024 pages of 256 bytes in 4 sectors.
*/
package flash_core_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ARRAY_AW = 18;                 // 262144 bytes
  localparam int PAGE_AW = 8;                   // 256 bytes a page
  localparam logic [15:0] PAGE_LAST = 16'h00FF;
  localparam logic [15:0] SECTOR_LAST = 16'hFFFF;
  localparam logic [1:0] PROT_SECTOR = 2'h0;    // lowest 256 pages
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2; // three address bytes

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;
  localparam logic [7:0] WRITE_LOCK_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
  localparam logic [7:0] PAGE_REWRITE_CMD = 8'h0A;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] PAGE_ERASE_CMD = 8'hDB;
  localparam logic [7:0] BLOCK_WIPE_CMD = 8'hD8;

  // ****************************************************************
  // Reset values and status layout
  // ****************************************************************
  localparam logic [2:0] BCNT_RESET = 3'h0;
  localparam logic [2:0] BCNT_BYTE = 3'h7;
  localparam logic [1:0] SYNC_CS_IDLE = 2'h3;
  localparam logic [5:0] STATUS_PAD = 6'h00;    // bits 7..2, then latch, busy

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    F_CMD = 3'b000,
    F_ADDR = 3'b001,
    F_DATA = 3'b010,
    F_OUT = 3'b011,
    F_IGNORE = 3'b100
  } frame_state_t;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_MERGE = 2'b01,
    P_ERASE = 2'b10,
    P_PROG = 2'b11
  } pass_t;

  typedef enum logic [1:0] {
    J_REWRITE = 2'b00,
    J_PROGRAM = 2'b01,
    J_PAGE_ERASE = 2'b10,
    J_SECTOR_ERASE = 2'b11
  } job_kind_t;

  typedef struct packed {
    job_kind_t kind;
    logic [ARRAY_AW-1:0] addr;
  } job_t;

endpackage : flash_core_pkg

// ==== src/serial_paged_flash_write_core.sv ====
/*
  Serial paged flash write core: SPI slave front end on the serial clock,
  command decoding, write protection and the internal rewrite, program
  and erase engine on the system clock, with array and page buffer RAMs.
  Assumes the master keeps sclk still while chip select is high or
  toggles it harmlessly, and bit periods far longer than a few clk cycles.
*/
`timescale 1ns/10ps

// Behaviour
// - Output bit changes on falling serial clock
// - Input bit sampled on rising serial clock
// - Output high impedance while deselected
// - Standby only when deselected and idle
// - No decoding before a chip select fall
// - Reset low and idle: outputs off
// - Running cycle survives reset low
// - Protect input low guards lowest pages
// - Clock idle low or high both work
// - Up to 256 bytes within one page
// - Data stored from low address byte
// - Rewrite starts on chip select rise
// - Unsupplied buffer bytes take old content
// - Rewrite erases page then programs buffer
// - Program only clears bits
// - Four sectors of 256 pages, 256 bytes
// - Page erase and sector erase supported
// - Busy flag readable during cycles
// - Unlock latch cleared on reset, lock, write or erase command
// - Execute only on whole byte frames
// - Most significant bit first
// - Array access ignored while busy
module serial_paged_flash_write_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic dev_reset_n,
  input wire logic wp_n,
  output logic miso,
  output logic miso_oe,
  output logic busy_flag,
  output logic standby
);

  // ****************************************************************
  // Link side, serial clock domain
  // ****************************************************************
  logic [2:0] lbit;
  logic [6:0] rx_sh;
  logic [7:0] rx_byte;
  logic bit_tgl;
  logic [6:0] tx_sh;
  logic [7:0] tx_byte;

  // Bit position in the frame, cleared by the frame's own select
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      lbit <= flash_core_pkg::BCNT_RESET;
    else
      lbit <= lbit + 3'h1;
  end

  // Shift in, most significant first, byte held for eight bit times
  always_ff @(posedge sclk)
  begin
    rx_sh <= {rx_sh[5:0], mosi};
    if (lbit == flash_core_pkg::BCNT_BYTE)
      rx_byte <= {rx_sh, mosi};
  end

  // One toggle per received bit, counted in the system domain
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
      bit_tgl <= 1'b0;
    else if (!cs_n)
      bit_tgl <= ~bit_tgl;
  end

  // Shift out on falling edges; tx_byte settles long before the load
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso <= 1'b0;
      tx_sh <= 7'h00;
    end
    else if (lbit == flash_core_pkg::BCNT_RESET)
    begin
      miso <= tx_byte[7];
      tx_sh <= tx_byte[6:0];
    end
    else
    begin
      miso <= tx_sh[6];
      tx_sh <= {tx_sh[5:0], 1'b0};
    end
  end

  // ****************************************************************
  // Pin synchronisers, system clock domain
  // ****************************************************************
  logic [1:0] cs_sync;
  logic [1:0] hr_sync;
  logic [1:0] wp_sync;
  logic [2:0] tg_sync;
  logic cs_prev;
  logic cs_end;

  // Two stages per pin, plus edge history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs_sync <= flash_core_pkg::SYNC_CS_IDLE;
      hr_sync <= 2'h0;
      wp_sync <= 2'h0;
      tg_sync <= 3'h0;
      cs_prev <= 1'b1;
      cs_end <= 1'b0;
    end
    else
    begin
      cs_sync <= {cs_sync[0], cs_n};
      hr_sync <= {hr_sync[0], dev_reset_n};
      wp_sync <= {wp_sync[0], wp_n};
      tg_sync <= {tg_sync[1:0], bit_tgl};
      cs_prev <= cs_sync[1];
      cs_end <= ~cs_prev & cs_sync[1];
    end
  end

  // Decoded pin levels and events
  wire cs_n_s = cs_sync[1];
  wire cs_fall = cs_prev & ~cs_n_s;
  wire bit_ev = tg_sync[2] ^ tg_sync[1];
  wire hw_rst_low = ~hr_sync[1];
  wire wp_low = ~wp_sync[1];
  wire in_reset = hw_rst_low & ~busy_flag;

  // ****************************************************************
  // Frame decoding
  // ****************************************************************
  flash_core_pkg::frame_state_t fst;
  flash_core_pkg::job_t job;
  flash_core_pkg::pass_t pass;
  logic [2:0] bcnt;
  logic [7:0] op;
  logic [17:0] addr;
  logic [1:0] acnt;
  logic [7:0] ptr;
  logic [255:0] sup;
  logic armed;
  logic unlock;
  logic [17:0] rd_addr;
  logic rd_pend;
  logic rd_pend_d;
  logic ph;
  logic [15:0] idx;
  logic [7:0] arr_rd;
  logic [7:0] buf_rd;

  wire byte_ev = bit_ev && (bcnt == flash_core_pkg::BCNT_BYTE);
  wire rx_addr_op = (rx_byte == flash_core_pkg::ARRAY_READ_CMD)
    || (rx_byte == flash_core_pkg::PAGE_REWRITE_CMD)
    || (rx_byte == flash_core_pkg::PAGE_PROGRAM_CMD)
    || (rx_byte == flash_core_pkg::PAGE_ERASE_CMD)
    || (rx_byte == flash_core_pkg::BLOCK_WIPE_CMD);
  wire op_write = (op == flash_core_pkg::PAGE_REWRITE_CMD)
    || (op == flash_core_pkg::PAGE_PROGRAM_CMD);
  wire op_erase = (op == flash_core_pkg::PAGE_ERASE_CMD)
    || (op == flash_core_pkg::BLOCK_WIPE_CMD);
  wire op_status = op == flash_core_pkg::STATUS_READ_CMD;
  wire prot = wp_low && (addr[17:16] == flash_core_pkg::PROT_SECTOR);
  wire exec = cs_end && armed && (bcnt == flash_core_pkg::BCNT_RESET)
    && !busy_flag;
  wire start_job = exec && unlock && (op_write || op_erase) && !prot;
  wire [7:0] status_byte = {flash_core_pkg::STATUS_PAD, unlock, busy_flag};

  // Bit counter, modulo eight, restarted by each select
  always_ff @(posedge clk)
  begin
    if (rst || cs_fall)
      bcnt <= {2'h0, bit_ev & ~rst};
    else if (bit_ev && !cs_n_s)
      bcnt <= bcnt + 3'h1;
  end

  // Frame state machine, one step per received byte
  always_ff @(posedge clk)
  begin
    rd_pend <= 1'b0;
    if (rst || in_reset)
    begin
      fst <= flash_core_pkg::F_IGNORE;
      armed <= 1'b0;
      acnt <= 2'h0;
    end
    else if (cs_fall)
    begin
      fst <= flash_core_pkg::F_CMD;
      armed <= 1'b0;
      acnt <= 2'h0;
    end
    else if (cs_end)
    begin
      fst <= flash_core_pkg::F_IGNORE;
      armed <= 1'b0;
    end
    else if (byte_ev)
    begin
      case (fst)
        flash_core_pkg::F_CMD:
        begin
          op <= rx_byte;
          if (rx_byte == flash_core_pkg::STATUS_READ_CMD)
            fst <= flash_core_pkg::F_OUT;
          else if (busy_flag)
            fst <= flash_core_pkg::F_IGNORE;
          else if (rx_addr_op)
            fst <= flash_core_pkg::F_ADDR;
          else
          begin
            fst <= flash_core_pkg::F_IGNORE;
            armed <= (rx_byte == flash_core_pkg::WRITE_UNLOCK_CMD)
              || (rx_byte == flash_core_pkg::WRITE_LOCK_CMD);
          end
        end
        flash_core_pkg::F_ADDR:
        begin
          addr <= {addr[9:0], rx_byte};
          acnt <= acnt + 2'h1;
          if (acnt == flash_core_pkg::ADDR_LAST_BYTE)
          begin
            rd_addr <= {addr[9:0], rx_byte};
            if (op == flash_core_pkg::ARRAY_READ_CMD)
            begin
              fst <= flash_core_pkg::F_OUT;
              rd_pend <= 1'b1;
            end
            else if (op_write)
            begin
              fst <= flash_core_pkg::F_DATA;
              ptr <= rx_byte;
              sup <= '0;
            end
            else
            begin
              fst <= flash_core_pkg::F_IGNORE;
              armed <= 1'b1;
            end
          end
        end
        flash_core_pkg::F_DATA:
        begin
          ptr <= ptr + 8'h01;
          sup[ptr] <= 1'b1;
          armed <= 1'b1;
        end
        flash_core_pkg::F_OUT:
        begin
          if (!op_status)
          begin
            rd_addr <= rd_addr + 18'h00001;
            rd_pend <= 1'b1;
          end
        end
        default:
          fst <= flash_core_pkg::F_IGNORE;
      endcase
    end
  end

  // Byte offered to the link for the next eight bit times
  always_ff @(posedge clk)
  begin
    rd_pend_d <= rd_pend;
    if (rst)
      tx_byte <= 8'h00;
    else if (rd_pend_d)
      tx_byte <= arr_rd;
    else if (byte_ev && ((fst == flash_core_pkg::F_OUT && op_status)
      || (fst == flash_core_pkg::F_CMD
      && rx_byte == flash_core_pkg::STATUS_READ_CMD)))
      tx_byte <= status_byte;
  end

  // Unlock latch
  always_ff @(posedge clk)
  begin
    if (rst || hw_rst_low)
      unlock <= 1'b0;
    else if (exec && op == flash_core_pkg::WRITE_UNLOCK_CMD)
      unlock <= 1'b1;
    else if (exec && (op == flash_core_pkg::WRITE_LOCK_CMD || op_write
      || op_erase))
      unlock <= 1'b0;
  end

  // ****************************************************************
  // Internal rewrite, program and erase engine
  // ****************************************************************
  wire flash_core_pkg::job_kind_t next_kind =
    (op == flash_core_pkg::PAGE_REWRITE_CMD) ? flash_core_pkg::J_REWRITE :
    (op == flash_core_pkg::PAGE_PROGRAM_CMD) ? flash_core_pkg::J_PROGRAM :
    (op == flash_core_pkg::PAGE_ERASE_CMD) ? flash_core_pkg::J_PAGE_ERASE :
    flash_core_pkg::J_SECTOR_ERASE;
  wire flash_core_pkg::pass_t first_pass =
    (next_kind == flash_core_pkg::J_REWRITE) ? flash_core_pkg::P_MERGE :
    (next_kind == flash_core_pkg::J_PROGRAM) ? flash_core_pkg::P_PROG :
    flash_core_pkg::P_ERASE;
  wire flash_core_pkg::pass_t next_pass =
    (pass == flash_core_pkg::P_MERGE) ? flash_core_pkg::P_ERASE :
    (pass == flash_core_pkg::P_ERASE && job.kind == flash_core_pkg::J_REWRITE)
    ? flash_core_pkg::P_PROG : flash_core_pkg::P_IDLE;
  wire [15:0] last_idx = (job.kind == flash_core_pkg::J_SECTOR_ERASE)
    ? flash_core_pkg::SECTOR_LAST : flash_core_pkg::PAGE_LAST;
  wire step_done = busy_flag && ph && (idx == last_idx);

  // Pass sequencing: read a byte, then write it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_flag <= 1'b0;
      pass <= flash_core_pkg::P_IDLE;
      ph <= 1'b0;
      idx <= 16'h0000;
      job <= '0;
    end
    else if (start_job)
    begin
      busy_flag <= 1'b1;
      job <= '{kind: next_kind, addr: addr};
      pass <= first_pass;
      ph <= 1'b0;
      idx <= 16'h0000;
    end
    else if (busy_flag)
    begin
      ph <= ~ph;
      if (step_done)
      begin
        idx <= 16'h0000;
        pass <= next_pass;
        busy_flag <= next_pass != flash_core_pkg::P_IDLE;
      end
      else if (ph)
        idx <= idx + 16'h0001;
    end
  end

  // Memory steering: engine while busy, frame otherwise
  wire [17:0] eng_addr = (job.kind == flash_core_pkg::J_SECTOR_ERASE)
    ? {job.addr[17:16], idx} : {job.addr[17:8], idx[7:0]};
  wire [17:0] arr_addr = busy_flag ? eng_addr : rd_addr;
  wire arr_we = busy_flag && ph && (pass == flash_core_pkg::P_ERASE
    || pass == flash_core_pkg::P_PROG);
  wire [7:0] prog_src = (job.kind == flash_core_pkg::J_REWRITE
    || sup[idx[7:0]]) ? buf_rd : flash_core_pkg::ERASED;
  wire [7:0] arr_wd = (pass == flash_core_pkg::P_ERASE)
    ? flash_core_pkg::ERASED : (arr_rd & prog_src);
  wire [7:0] buf_addr = busy_flag ? idx[7:0] : ptr;
  wire buf_we = busy_flag
    ? (ph && pass == flash_core_pkg::P_MERGE && !sup[idx[7:0]])
    : (byte_ev && fst == flash_core_pkg::F_DATA);
  wire [7:0] buf_wd = busy_flag ? arr_rd : rx_byte;

  // Array and page buffer
  byte_ram #(.AW(flash_core_pkg::ARRAY_AW)) u_array (
    .clk(clk),
    .we(arr_we),
    .addr(arr_addr),
    .wdata(arr_wd),
    .rdata(arr_rd)
  );

  byte_ram #(.AW(flash_core_pkg::PAGE_AW)) u_page_buf (
    .clk(clk),
    .we(buf_we),
    .addr(buf_addr),
    .wdata(buf_wd),
    .rdata(buf_rd)
  );

  // ****************************************************************
  // Pin enables and power state
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      miso_oe <= 1'b0;
      standby <= 1'b1;
    end
    else
    begin
      miso_oe <= !cs_n_s && !in_reset;
      standby <= cs_n_s && !busy_flag;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_last_write;
    step_done && next_pass == flash_core_pkg::P_IDLE;
  endsequence

  sequence s_deselect;
    cs_n_s ##1 cs_n_s;
  endsequence

  AST_OE_OFF_DESELECT: assert property (s_deselect |-> !miso_oe)
    else $error("output enabled while deselected");
  AST_STANDBY_IDLE: assert property (
    busy_flag |=> !standby)
    else $error("standby during internal cycle");
  AST_DECODE_AFTER_FALL: assert property (
    $rose(fst == flash_core_pkg::F_CMD) |-> $past(cs_fall))
    else $error("decoding began without select fall");
  AST_RESET_HIZ: assert property (in_reset ##1 in_reset |-> !miso_oe)
    else $error("output enabled in reset mode");
  AST_BUSY_SURVIVES_RESET: assert property (
    busy_flag && hw_rst_low && !step_done |=> busy_flag)
    else $error("reset cut an internal cycle");
  AST_PROTECT: assert property (
    cs_end && wp_low && addr[17:16] == flash_core_pkg::PROT_SECTOR
    && !busy_flag |=> !busy_flag)
    else $error("protected page modified");
  AST_BUF_STORE: assert property (
    byte_ev && fst == flash_core_pkg::F_DATA && !busy_flag
    |-> buf_we && buf_addr == ptr ##1 ptr == $past(ptr) + 8'h01)
    else $error("data byte not stored at offset");
  AST_START_ON_RISE: assert property (
    $rose(busy_flag) |-> $past(cs_end))
    else $error("cycle started without select rise");
  AST_ERASE_ONES: assert property (
    arr_we && pass == flash_core_pkg::P_ERASE |-> arr_wd == 8'hFF)
    else $error("erase wrote zero bits");
  AST_PROG_CLEARS_ONLY: assert property (
    arr_we && job.kind == flash_core_pkg::J_PROGRAM
    |-> (arr_wd & ~arr_rd) == 8'h00)
    else $error("program set a bit");
  AST_LATCH_CLEARED: assert property (start_job |=> !unlock)
    else $error("unlock latch survived command");
  AST_WHOLE_BYTES: assert property (
    cs_end && bcnt != flash_core_pkg::BCNT_RESET && !busy_flag
    |=> !busy_flag)
    else $error("partial frame executed");
  AST_BUSY_IGNORE: assert property (
    busy_flag && byte_ev && fst == flash_core_pkg::F_CMD
    |=> fst != flash_core_pkg::F_ADDR)
    else $error("array access taken while busy");
  AST_BUSY_DROPS: assert property (s_last_write |=> !busy_flag)
    else $error("busy stayed after last write");

endmodule : serial_paged_flash_write_core

// ==== verification/spi_master_model.sv ====
/*
  Behavioural SPI bus master that drives the flash write core's link.
  Assumes the bench calls its tasks one at a time; 125 ns serial clock.
*/
`timescale 1ns/10ps
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ****************************************************************
  // Line state
  // ****************************************************************
  localparam realtime HALF = 62.5;
  logic mode3;
  logic [7:0] rx_last;
  event got;
  wire q_line;

  // Undriven output line shows the inverse of the flop's level
  assign q_line = miso_oe ? miso : ~miso;

  // Idle levels at time zero, deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    mode3 = 1'b0;
    rx_last = 8'h00;
  end

  // Select with the clock resting at the idle level of the mode
  task start(input logic m3);
    mode3 = m3;
    sclk = m3;
    #(HALF);
    cs_n = 1'b0;
    #(HALF);
  endtask : start

  // Shift n bits out and in; mark a received byte on request
  task bits(input logic [7:0] tx, input int n, input logic rd);
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b0;
      mosi = tx[7 - i];
      #(HALF);
      rx_last = {rx_last[6:0], q_line};
      sclk = 1'b1;
      #(HALF);
    end
    if (rd)
      -> got;
  endtask : bits

  // Clock back to idle, deselect, leave a gap between frames
  task stop;
    if (!mode3)
    begin
      sclk = 1'b0;
      #(HALF);
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask : stop
endmodule : spi_master_model

// ==== verification/tb.sv ====
/*
  Self-checking bench for the serial paged flash write core.
  Assumes the SPI master model in its own file and the core package.
*/
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("BAD %0t got %h expected %h", $time, a, b); \
    end \
  end
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk;
  logic rst;
  logic dev_reset_n;
  logic wp_n;
  wire sclk;
  wire cs_n;
  wire mosi;
  wire miso;
  wire miso_oe;
  wire busy_flag;
  wire standby;
  int err_total;
  int check_count;
  logic [7:0] exp_q[$];
  logic [7:0] exp_b;
  logic [7:0] da;
  logic [7:0] db;
  logic [7:0] dc;
  logic [7:0] de;
  logic [7:0] off;
  logic [17:0] pg;
  logic [17:0] ad;

  always #2 clk = ~clk;

  serial_paged_flash_write_core DUT (.clk(clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .dev_reset_n(dev_reset_n), .wp_n(wp_n),
    .miso(miso), .miso_oe(miso_oe), .busy_flag(busy_flag),
    .standby(standby));
  spi_master_model MST (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe));

  // Received byte against the oldest note
  always @(MST.got)
  begin
    exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : ~MST.rx_last;
    `CHK(MST.rx_last, exp_b)
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task send_addr(input logic [17:0] a);
    MST.bits({6'h00, a[17:16]}, 8, 1'b0);
    MST.bits(a[15:8], 8, 1'b0);
    MST.bits(a[7:0], 8, 1'b0);
  endtask : send_addr

  task cmd(input logic [7:0] op);
    MST.start(1'b0);
    MST.bits(op, 8, 1'b0);
    MST.stop();
  endtask : cmd

  task status_exp(input logic [7:0] e, input logic m3);
    exp_q.push_back(e);
    MST.start(m3);
    MST.bits(flash_core_pkg::STATUS_READ_CMD, 8, 1'b0);
    MST.bits(8'h00, 8, 1'b1);
    MST.stop();
  endtask : status_exp

  task read_exp(input logic [17:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    MST.start(1'b0);
    MST.bits(flash_core_pkg::ARRAY_READ_CMD, 8, 1'b0);
    send_addr(a);
    MST.bits(8'h00, 8, 1'b1);
    MST.stop();
  endtask : read_exp

  // Unlock, then one modifying frame with up to two data bytes
  task modify(input logic [7:0] op, input logic [17:0] a, input int n,
    input logic [15:0] d);
    cmd(flash_core_pkg::WRITE_UNLOCK_CMD);
    MST.start(1'b0);
    MST.bits(op, 8, 1'b0);
    send_addr(a);
    for (int i = 0; i < n; i++)
      MST.bits(d[15 - 8 * i -: 8], 8, 1'b0);
    MST.stop();
  endtask : modify

  task wait_idle;
    int i;
    for (i = 0; i < 8000; i++)
    begin
      @(negedge clk);
      if (busy_flag === 1'b0)
        break;
    end
    if (i == 8000)
    begin
      err_total++;
      $display("BAD %0t busy never cleared", $time);
      final_report();
    end
  endtask : wait_idle

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    dev_reset_n = 1'b0;
    wp_n = 1'b1;
    err_total = 0;
    check_count = 0;
    da = 8'($urandom(32'h39F8));
    db = 8'($urandom);
    dc = 8'($urandom);
    de = 8'($urandom);
    off = 8'($urandom_range(254));
    pg = {2'(1 + $urandom_range(2)), 8'($urandom), 8'h00};
    ad = pg | 18'(off);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    dev_reset_n = 1'b1;
    @(negedge clk);
    `CHK(miso_oe, 1'b0)
    `CHK(busy_flag, 1'b0)
    `CHK(standby, 1'b1)
    repeat (10) @(negedge clk);
    status_exp(8'h00, 1'b0);
    cmd(flash_core_pkg::WRITE_UNLOCK_CMD);
    status_exp(8'h02, 1'b1);
    MST.start(1'b0);
    MST.bits(flash_core_pkg::WRITE_LOCK_CMD, 8, 1'b0);
    MST.bits(8'h00, 1, 1'b0);
    MST.stop();
    status_exp(8'h02, 1'b0);
    cmd(flash_core_pkg::WRITE_LOCK_CMD);
    status_exp(8'h00, 1'b0);
    $display("test latch done");
    modify(flash_core_pkg::PAGE_ERASE_CMD, pg, 0, 16'h0000);
    wait_idle();
    read_exp(ad, 8'hFF);
    modify(flash_core_pkg::PAGE_PROGRAM_CMD, ad, 1, {da, 8'h00});
    wait_idle();
    modify(flash_core_pkg::PAGE_PROGRAM_CMD, ad, 1, {db, 8'h00});
    wait_idle();
    read_exp(ad, da & db);
    modify(flash_core_pkg::PAGE_REWRITE_CMD, ad + 18'h00001, 1, {dc, 8'h00});
    @(negedge clk);
    `CHK(busy_flag, 1'b1)
    `CHK(standby, 1'b0)
    status_exp(8'h01, 1'b0);
    cmd(flash_core_pkg::WRITE_UNLOCK_CMD);
    @(negedge clk);
    dev_reset_n = 1'b0;
    repeat (100) @(negedge clk);
    `CHK(busy_flag, 1'b1)
    wait_idle();
    repeat (2) @(negedge clk);
    `CHK(standby, 1'b1)
    cmd(flash_core_pkg::WRITE_UNLOCK_CMD);
    @(negedge clk);
    dev_reset_n = 1'b1;
    repeat (10) @(negedge clk);
    status_exp(8'h00, 1'b0);
    read_exp(ad, da & db);
    read_exp(ad + 18'h00001, dc);
    modify(flash_core_pkg::PAGE_REWRITE_CMD, pg | 18'h000FF, 2, {de, dc});
    wait_idle();
    read_exp(pg | 18'h000FF, de);
    read_exp(pg, dc);
    $display("test page done");
    @(negedge clk);
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    modify(flash_core_pkg::PAGE_PROGRAM_CMD, 18'h00010, 1, 16'h0000);
    @(negedge clk);
    `CHK(busy_flag, 1'b0)
    modify(flash_core_pkg::BLOCK_WIPE_CMD, 18'h00000, 0, 16'h0000);
    @(negedge clk);
    `CHK(busy_flag, 1'b0)
    status_exp(8'h00, 1'b0);
    @(negedge clk);
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    modify(flash_core_pkg::PAGE_ERASE_CMD, 18'h00000, 0, 16'h0000);
    @(negedge clk);
    `CHK(busy_flag, 1'b1)
    wait_idle();
    read_exp(18'h00010, 8'hFF);
    $display("test protect done");
    `CHK(exp_q.size() == 0, 1'b1)
    final_report();
  end
endmodule : tb
